// ===== tb/bus_partner.sv
/*
 Opposite-kind node model: sends one sync word on each source in the mask.
 Assumes masks change by non-blocking assignment at the falling edge.
*/
`timescale 1ns/1ps
`include "bus_supervisor_consts.vh"
module bus_partner #(
	parameter NSRC = 4,
	parameter MSG_W = 16
) (
	input wire sys_clk,
	input wire [NSRC-1:0] sendMask,
	input wire [NSRC-1:0] badMask,
	output reg [NSRC-1:0] rxStrobe,
	output reg [NSRC*MSG_W-1:0] rxMessage,
	output reg [NSRC-1:0] rxSynd
);
	reg [MSG_W-1:0] noise;
	integer g;
	initial begin
		rxStrobe = {NSRC{1'b0}};
		rxSynd = {NSRC{1'b0}};
		rxMessage = {NSRC*MSG_W{1'b0}};
		noise = {MSG_W{1'b0}};
	end
	// Idle words churn so a stale word never looks valid
	always @(negedge sys_clk) begin
		noise <= noise + 1'b1;
		rxStrobe <= sendMask;
		rxSynd <= badMask & sendMask;
		for (g = 0; g < NSRC; g = g + 1)
			rxMessage[g*MSG_W+:MSG_W] <= sendMask[g] ? {{(MSG_W-2){1'b0}}, `MSG_SYNC} : ~noise;
	end
endmodule // bus_partner

// ===== tb/bus_supervisor_chk.sv
/*
 Checker for the bus supervisor top-level ports.
 Assumes one clock domain and a bind onto every bus_supervisor instance.
*/
`timescale 1ns/1ps
`include "bus_supervisor_consts.vh"
module bus_supervisor_chk #(
	parameter NSRC = 4,
	parameter KSCHED_W = 4,
	parameter SYNC_TIMEOUT = 50
) (
	input wire sys_clk,
	input wire rstn,
	input wire resetIn,
	input wire failureIn,
	input wire enableIn,
	input wire nodeKindSelect,
	input wire cmdValid,
	input wire [`MODE_W-1:0] cmdMode,
	input wire [KSCHED_W-1:0] cmdSchedCount,
	input wire [NSRC-1:0] rxStrobe,
	input wire [NSRC-1:0] rxSynd,
	input wire cmdReady_r,
	input wire failureOut_r,
	input wire [NSRC-1:0] accusation_r,
	input wire txStrobe_r,
	input wire peRead_r,
	input wire peStrobe_r,
	input wire [`MODE_W-1:0] activeMode_r
);
	reg en_r;
	reg inBc_r;
	reg [7:0] txCnt_r;
	reg [KSCHED_W-1:0] kLat_r;
	reg [15:0] capCnt_r;
	wire inSync = activeMode_r == `MODE_CAPTURE || activeMode_r == `MODE_INITSYNC;
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			en_r <= 1'b0;
			inBc_r <= 1'b0;
			txCnt_r <= 8'h0;
			kLat_r <= {KSCHED_W{1'b0}};
			capCnt_r <= 16'h0;
		end else begin
			en_r <= !resetIn && (en_r || enableIn);
			capCnt_r <= inSync ? capCnt_r + 16'h1 : 16'h0;
			if (activeMode_r == `MODE_BROADCAST && !inBc_r) begin
				inBc_r <= 1'b1;
				txCnt_r <= 8'h0;
				kLat_r <= cmdSchedCount;
			end else if (inBc_r) begin
				txCnt_r <= txCnt_r + {7'h0, txStrobe_r};
				inBc_r <= !cmdReady_r;
			end
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	chk_fail_hold: assert property (failureOut_r && !resetIn |=> failureOut_r)
		else $error("failure output dropped without reset");
	chk_fail_input: assert property (failureIn && !resetIn |=> failureOut_r)
		else $error("failure input not reflected");
	chk_accuse_kept: assert property (!resetIn |=> (accusation_r & $past(accusation_r)) == $past(accusation_r))
		else $error("accusation withdrawn without reset");
	chk_accuse_fast: assert property (inSync && rxStrobe[0] && rxSynd[0] && !resetIn |-> ##2 accusation_r[0])
		else $error("bad input not accused at once");
	chk_reset_quiet: assert property (resetIn |=> !cmdReady_r && !txStrobe_r && activeMode_r == `MODE_IDLE)
		else $error("outputs active after reset");
	chk_idle_wait: assert property (!en_r && !enableIn |=> !cmdReady_r)
		else $error("ready before enable");
	chk_capture_taken: assert property (cmdReady_r && cmdValid && cmdMode == `MODE_CAPTURE && !resetIn
		|-> ##[1:2] activeMode_r == `MODE_CAPTURE)
		else $error("capture command not taken");
	chk_sync_bound: assert property (capCnt_r <= SYNC_TIMEOUT + 4)
		else $error("sync protocol outlived its timeout");
	chk_bcast_count: assert property (inBc_r && cmdReady_r |-> txCnt_r == kLat_r + 8'h1)
		else $error("broadcast word count wrong");
	chk_pe_gate: assert property (peRead_r || peStrobe_r |-> nodeKindSelect == `KIND_BIU)
		else $error("element port active in management role");
	cover property (inBc_r && cmdReady_r);
	cover property (failureOut_r);
	cover property (accusation_r != 0);
endmodule // bus_supervisor_chk
bind bus_supervisor bus_supervisor_chk #(.NSRC(NSRC), .KSCHED_W(KSCHED_W), .SYNC_TIMEOUT(SYNC_TIMEOUT)) i_chk (
	.sys_clk, .rstn, .resetIn, .failureIn, .enableIn, .nodeKindSelect, .cmdValid, .cmdMode, .cmdSchedCount,
	.rxStrobe, .rxSynd, .cmdReady_r, .failureOut_r, .accusation_r, .txStrobe_r, .peRead_r, .peStrobe_r,
	.activeMode_r);

// ===== tb/bus_supervisor_tb.sv
/*
 Self-checking bench for the bus supervisor with one partner model.
 Assumes short sync timeouts and a one-tick introduction interval.
*/
`timescale 1ns/1ps
`include "bus_supervisor_consts.vh"
module bus_supervisor_tb;
	localparam SYNC_T = 50;
	reg sys_clk = 1'b0;
	reg rstn = 1'b0;
	reg resetIn = 1'b0;
	reg failureIn = 1'b0;
	reg enableIn = 1'b0;
	reg nodeKindSelect = `KIND_BIU;
	reg [2:0] nodeNumberSelect = 3'h5;
	reg cmdValid = 1'b0;
	reg [2:0] cmdMode = 3'h0;
	reg [3:0] cmdSchedCount = 4'h0;
	reg [2:0] cmdSchedNode = 3'h0;
	reg [3:0] sendMask = 4'h0;
	reg [3:0] badMask = 4'h0;
	reg [3:0] crossLaneFlag = 4'h0;
	reg [15:0] peMessage = 16'h5a5a;
	reg [15:0] last;
	wire [3:0] rxStrobe, rxSynd, accusation_r;
	wire [63:0] rxMessage;
	wire cmdReady_r, failureOut_r, txStrobe_r, peRead_r, peStrobe_r, syncReset_r;
	wire [15:0] txMessage_r, peOutMessage_r;
	wire [2:0] activeMode_r;
	integer err_total = 0;
	integer num_checks = 0;
	integer n, p, q, s;
	always #2.5 sys_clk = ~sys_clk;
	bus_supervisor #(.DATA_INTRODUCTION_INTERVAL(1), .SYNC_TIMEOUT(SYNC_T), .RESYNC_TIMEOUT(200)) i_dut (
		.sys_clk, .rstn, .resetIn, .failureIn, .enableIn, .nodeKindSelect, .nodeNumberSelect, .cmdValid,
		.cmdMode, .cmdSchedCount, .cmdSchedNode, .crossLaneFlag, .rxStrobe, .rxMessage, .rxSynd,
		.peMessage, .peSynd(1'b0), .cmdReady_r, .failureOut_r, .accusation_r, .txStrobe_r, .txMessage_r,
		.peRead_r, .peStrobe_r, .peOutMessage_r, .activeMode_r, .syncReset_r);
	bus_partner i_partner (.sys_clk, .sendMask, .badMask, .rxStrobe, .rxMessage, .rxSynd);
	////////////////////////////////////////
	task chk1(input string name, input logic e, input logic g);
		num_checks = num_checks + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("mismatch %0s expected %b seen %b", name, e, g);
		end
	endtask
	task chkv(input string name, input logic [15:0] e, input logic [15:0] g);
		num_checks = num_checks + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("mismatch %0s expected %h seen %h", name, e, g);
		end
	endtask
	task cmd(input [2:0] m, input [3:0] k, input [2:0] nd);
		integer i;
		cmdMode = m;
		cmdSchedCount = k;
		cmdSchedNode = nd;
		cmdValid = 1'b1;
		for (i = 0; i < 300 && cmdReady_r !== 1'b0; i = i + 1)
			@(negedge sys_clk);
		cmdValid = 1'b0;
		chk1("taken", 1'b0, cmdReady_r);
	endtask
	task pulse(input [3:0] m, input [3:0] b);
		sendMask <= m;
		badMask <= b;
		@(negedge sys_clk);
		sendMask <= 4'h0;
		badMask <= 4'h0;
		repeat (3) @(negedge sys_clk);
	endtask
	task t_enable;
		repeat (10) @(negedge sys_clk);
		chk1("ready before enable", 1'b0, cmdReady_r);
		enableIn = 1'b1;
		repeat (3) @(negedge sys_clk);
		enableIn = 1'b0;
		chk1("ready after enable", 1'b1, cmdReady_r);
		$display("test enable done");
	endtask
	task t_bcast(input [3:0] k, input [2:0] nd, input [15:0] expRd);
		n = 0;
		p = 0;
		q = 0;
		last = 16'hffff;
		sendMask <= 4'h1;
		cmd(`MODE_BROADCAST, k, nd);
		for (s = 0; s < 100 && cmdReady_r !== 1'b1; s = s + 1) begin
			@(negedge sys_clk);
			n = n + (txStrobe_r === 1'b1);
			p = p + (peRead_r === 1'b1);
			q = q + (peStrobe_r === 1'b1);
			if (txStrobe_r === 1'b1)
				last = txMessage_r;
		end
		sendMask <= 4'h0;
		@(negedge sys_clk);
		chk1("element delivery", nodeKindSelect == `KIND_BIU, q > 0);
		if (nodeKindSelect == `KIND_BIU)
			chkv("element word", {14'h0, `MSG_SYNC}, peOutMessage_r);
		chkv("strobes", 16'(k) + 16'h1, n[15:0]);
		chkv("element reads", expRd, p[15:0]);
		chkv("accusation word", 16'h0, last);
		$display("test broadcast done");
	endtask
	task t_capture;
		cmd(`MODE_CAPTURE, 4'h0, 3'h0);
		pulse(4'h1, 4'h1);
		chk1("accuse bad source", 1'b1, accusation_r[0]);
		pulse(4'h2, 4'h0);
		chk1("still capturing", 1'b1, activeMode_r == `MODE_CAPTURE);
		s = 0;
		// Sync reset stands one cycle, so watch from the send on
		sendMask <= 4'hc;
		@(negedge sys_clk);
		sendMask <= 4'h0;
		for (n = 0; n < 20 && cmdReady_r !== 1'b1; n = n + 1) begin
			if (syncReset_r === 1'b1)
				s = 1;
			@(negedge sys_clk);
		end
		chk1("capture done", 1'b1, s == 1 || syncReset_r === 1'b1);
		chk1("voters survive", 1'b0, failureOut_r);
		chk1("accusation kept", 1'b1, accusation_r[0]);
		$display("test capture done");
	endtask
	task t_timeout;
		cmd(`MODE_CAPTURE, 4'h0, 3'h0);
		// Cross-lane flags leave too few voters, so only the timeout ends it
		crossLaneFlag = 4'hc;
		pulse(4'he, 4'h0);
		for (n = 4; n < SYNC_T + 10 && failureOut_r !== 1'b1; n = n + 1)
			@(negedge sys_clk);
		crossLaneFlag = 4'h0;
		chk1("timeout failure", 1'b1, failureOut_r);
		chk1("not early", 1'b1, n >= SYNC_T - 2);
		chk1("not late", 1'b1, n <= SYNC_T + 2);
		repeat (20) @(negedge sys_clk);
		chk1("failure held", 1'b1, failureOut_r);
		resetIn = 1'b1;
		repeat (2) @(negedge sys_clk);
		resetIn = 1'b0;
		chk1("failure cleared", 1'b0, failureOut_r);
		$display("test timeout done");
	endtask
	task t_failin;
		failureIn = 1'b1;
		@(negedge sys_clk);
		failureIn = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk1("failure input", 1'b1, failureOut_r);
		$display("test failure input done");
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (8) @(negedge sys_clk);
		rstn = 1'b1;
		t_enable;
		t_bcast(4'h3, 3'h5, 16'h3);
		t_bcast(4'h0, 3'h2, 16'h0);
		t_capture;
		t_timeout;
		nodeKindSelect = 1'b1;
		t_enable;
		t_bcast(4'h2, 3'h5, 16'h0);
		t_failin;
		print_verdict;
	end
	// Tests need under 200 cycles; 20000 cycles means a hang
	initial begin
		#100000;
		err_total = err_total + 1;
		print_verdict;
	end
endmodule // bus_supervisor_tb

// ===== verilog/bus_supervisor.v
/*
 Supervisory core of the fault-tolerant bus protocol processor: mode sequencing,
 per-source input monitoring, voter checks, sync and resync timeouts, broadcast
 transmission and processing-element port gating.
 Assumes all inputs synchronous to sys_clk; commands arrive on cmdValid with mode bits.
*/
// Functional notes
// - Monitor inputs during frame sync, capture and initial sync, alongside protocol.
// - One independent monitor for each opposite-kind source.
// - Flag error when a source's message sequence is invalid for current protocol.
// - Accuse a failing source immediately.
// - Frame sync syndromes shape the voter set latched at capture start.
// - Latch voters at sync start; fail unless a majority survive at end.
// - Final voter set excludes monitor and cross-lane flagged sources.
// - Timeout on acquisition and initial sync aborts and declares failure.
// - Sync completes only after messages from a majority of eligible voters.
// - Time resync intervals capture/initsync to preserve and preserve to preserve.
// - Accept schedule update messages at any interval of one tick or more.
// - Accept broadcast messages at any interval of one tick or more.
// - Scheduled unit sends element message, others send accusation diagnostics.
// - Accusation exchange follows last broadcast after one interval; count plus one.
// - Node kind input selects interface or management unit behaviour.
// - Reset and enable inputs; failure output for local or bus failure.
// - Node number comes from external select input.
// - Self-test mode only passes through, no real test.
// - Element interface active only as interface unit.
// - Diagnosis only after time sync; loop protocols start from local-time triggers.
// - Finish current minor mode before next command; command carries mode info.
// - Transmit and receive simultaneously without blocking.
// - Reset acts on the oscillator clock.
// - Idle after reset until enable; then enable ignored until reset.
`timescale 1ns/1ps
`include "bus_supervisor_consts.vh"
module bus_supervisor #(
	parameter NSRC = 4,
	parameter MSG_W = 16,
	parameter ID_W = 3,
	parameter DATA_INTRODUCTION_INTERVAL = 1,
	parameter KSCHED_W = 4,
	parameter SYNC_TIMEOUT = `SYNC_TIMEOUT_CYC,
	parameter RESYNC_TIMEOUT = `RESYNC_TIMEOUT_CYC,
	parameter LOOP_PERIOD = 64
) (
	input wire sys_clk,
	input wire rstn,
	input wire resetIn,
	input wire failureIn,
	input wire enableIn,
	input wire nodeKindSelect,
	input wire [ID_W-1:0] nodeNumberSelect,
	input wire cmdValid,
	input wire [`MODE_W-1:0] cmdMode,
	input wire [KSCHED_W-1:0] cmdSchedCount,
	input wire [ID_W-1:0] cmdSchedNode,
	input wire [NSRC-1:0] crossLaneFlag,
	input wire [NSRC-1:0] rxStrobe,
	input wire [NSRC*MSG_W-1:0] rxMessage,
	input wire [NSRC-1:0] rxSynd,
	input wire [MSG_W-1:0] peMessage,
	input wire peSynd,
	output reg cmdReady_r,
	output reg failureOut_r,
	output reg [NSRC-1:0] accusation_r,
	output reg txStrobe_r,
	output reg [MSG_W-1:0] txMessage_r,
	output reg peRead_r,
	output reg peStrobe_r,
	output reg [MSG_W-1:0] peOutMessage_r,
	output reg [`MODE_W-1:0] activeMode_r,
	output reg syncReset_r
);
	localparam ST_HOLD = 2'h0;
	localparam ST_READY = 2'h1;
	localparam ST_RUN = 2'h2;
	localparam [31:0] DIIM1 = DATA_INTRODUCTION_INTERVAL - 1;
	localparam CW = 24;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg nodeKind_r;
	reg [ID_W-1:0] nodeId_r;
	reg [NSRC-1:0] eligible_r;
	reg [NSRC-1:0] latched_r;
	reg [CW-1:0] syncTimer_r;
	reg [CW-1:0] resyncTimer_r;
	reg resyncArmed_r;
	reg [CW-1:0] localTime_r;
	reg timeSynced_r;
	reg [KSCHED_W:0] txLeft_r;
	reg [31:0] diiCnt_r;
	reg [KSCHED_W-1:0] schedCount_r;
	reg [ID_W-1:0] schedNode_r;
	reg resetInD_r;

	wire [NSRC-1:0] monAccuse;
	wire [NSRC-1:0] monSync;
	wire isBiu;
	wire syncMode;
	wire startPulse;
	wire monClear;
	assign isBiu = (nodeKind_r == `KIND_BIU);
	assign syncMode = (activeMode_r == `MODE_CAPTURE) || (activeMode_r == `MODE_INITSYNC);
	assign startPulse = (state_r == ST_READY) && cmdValid;
	// Monitors forget old verdicts on a synchronous reset too
	assign monClear = startPulse || resetIn;

	function [7:0] popCount;
		input [NSRC-1:0] v;
		integer i;
		begin
			popCount = 8'h00;
			for (i = 0; i < NSRC; i = i + 1)
				popCount = popCount + {7'h00, v[i]};
		end
	endfunction

	// Two sets a and b: strict majority of a present in b
	function majorityOf;
		input [NSRC-1:0] a;
		input [NSRC-1:0] b;
		begin
			majorityOf = ({popCount(a & b), 1'b0} > {1'b0, popCount(a)});
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < NSRC; g = g + 1) begin : gMon
			input_error_monitor #(.MSG_W(MSG_W)) uMon (
				.sys_clk(sys_clk),
				.rstn(rstn),
				.clear(monClear),
				.mode(activeMode_r),
				.strobe(rxStrobe[g] && state_r == ST_RUN && !resetIn),
				.message(rxMessage[g*MSG_W +: MSG_W]),
				.rxSynd(rxSynd[g]),
				.accuse_r(monAccuse[g]),
				.syncSeen_r(monSync[g])
			);
		end
	endgenerate

	wire [NSRC-1:0] finalSet;
	assign finalSet = eligible_r & ~monAccuse & ~crossLaneFlag;
	wire syncDone;
	assign syncDone = syncMode && majorityOf(latched_r, finalSet & monSync);
	wire syncExpire;
	assign syncExpire = syncMode && (syncTimer_r >= SYNC_TIMEOUT[CW-1:0]);
	wire resyncExpire;
	assign resyncExpire = resyncArmed_r && (resyncTimer_r >= RESYNC_TIMEOUT[CW-1:0]);
	wire txDone;
	assign txDone = (activeMode_r == `MODE_BROADCAST) && (txLeft_r == {(KSCHED_W+1){1'b0}});
	wire modeDone;
	assign modeDone = syncDone || syncExpire || txDone ||
		(activeMode_r == `MODE_SELFTEST) || (activeMode_r == `MODE_FRAMESYNC) ||
		(activeMode_r == `MODE_PRESERVE) || (activeMode_r == `MODE_DIAG) || (activeMode_r == `MODE_IDLE);
	wire cmdAllowed;
	// Diagnosis waits for time sync; loop modes fire on local-time wrap
	assign cmdAllowed = (cmdMode != `MODE_DIAG || timeSynced_r) &&
		(!timeSynced_r || localTime_r == LOOP_PERIOD[CW-1:0] - 1'b1 || cmdMode == `MODE_CAPTURE);

	////////////////////////////////////////////////////////////////////////
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_HOLD: if (enableIn) state_nxt = ST_READY;
			ST_READY: if (cmdValid && cmdAllowed) state_nxt = ST_RUN;
			ST_RUN: if (modeDone) state_nxt = ST_READY;
			default: state_nxt = ST_HOLD;
		endcase
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			resetInD_r <= 1'b0;
		end else begin
			resetInD_r <= resetIn;
		end
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_HOLD;
			nodeKind_r <= `KIND_BIU;
			nodeId_r <= {ID_W{1'b0}};
			cmdReady_r <= 1'b0;
			failureOut_r <= 1'b0;
			accusation_r <= {NSRC{1'b0}};
			eligible_r <= {NSRC{1'b1}};
			latched_r <= {NSRC{1'b0}};
			syncTimer_r <= {CW{1'b0}};
			resyncTimer_r <= {CW{1'b0}};
			resyncArmed_r <= 1'b0;
			localTime_r <= {CW{1'b0}};
			timeSynced_r <= 1'b0;
			activeMode_r <= `MODE_IDLE;
			syncReset_r <= 1'b0;
			schedCount_r <= {KSCHED_W{1'b0}};
			schedNode_r <= {ID_W{1'b0}};
		end else if (resetIn) begin
			state_r <= ST_HOLD;
			cmdReady_r <= 1'b0;
			failureOut_r <= 1'b0;
			accusation_r <= {NSRC{1'b0}};
			eligible_r <= {NSRC{1'b1}};
			latched_r <= {NSRC{1'b0}};
			syncTimer_r <= {CW{1'b0}};
			resyncTimer_r <= {CW{1'b0}};
			resyncArmed_r <= 1'b0;
			localTime_r <= {CW{1'b0}};
			timeSynced_r <= 1'b0;
			activeMode_r <= `MODE_IDLE;
			syncReset_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cmdReady_r <= (state_nxt == ST_READY);
			syncReset_r <= 1'b0;
			localTime_r <= (localTime_r == LOOP_PERIOD[CW-1:0] - 1'b1) ? {CW{1'b0}} : localTime_r + 1'b1;
			if (state_r == ST_HOLD && enableIn) begin
				nodeKind_r <= nodeKindSelect;
				nodeId_r <= nodeNumberSelect;
			end
			// A fault stays flagged: the region resets as a whole
			if (syncExpire || resyncExpire || failureIn || (state_r == ST_RUN && syncMode && modeDone && !syncDone))
				failureOut_r <= 1'b1;
			accusation_r <= accusation_r | monAccuse;
			if (startPulse && cmdAllowed) begin
				activeMode_r <= cmdMode;
				schedCount_r <= cmdSchedCount;
				schedNode_r <= cmdSchedNode;
				syncTimer_r <= {CW{1'b0}};
				if (cmdMode == `MODE_CAPTURE || cmdMode == `MODE_INITSYNC)
					latched_r <= eligible_r & ~accusation_r & ~monAccuse;
			end else if (state_r == ST_RUN) begin
				if (syncMode)
					syncTimer_r <= syncTimer_r + 1'b1;
				if (modeDone) begin
					activeMode_r <= `MODE_IDLE;
					if (activeMode_r == `MODE_FRAMESYNC)
						eligible_r <= eligible_r & ~monAccuse;
					if (syncMode) begin
						eligible_r <= finalSet;
						if (!majorityOf(latched_r, finalSet))
							failureOut_r <= 1'b1;
					end
					if (syncDone || activeMode_r == `MODE_PRESERVE) begin
						syncReset_r <= 1'b1;
						timeSynced_r <= 1'b1;
						localTime_r <= {CW{1'b0}};
						resyncTimer_r <= {CW{1'b0}};
						resyncArmed_r <= 1'b1;
					end
				end
			end
			if (!(state_r == ST_RUN && modeDone && (syncDone || activeMode_r == `MODE_PRESERVE)) && resyncArmed_r)
				resyncTimer_r <= resyncTimer_r + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit path: free of receive path so both run each tick
	wire txTick;
	assign txTick = (activeMode_r == `MODE_BROADCAST) && (diiCnt_r == 32'h00000000) && (txLeft_r != 0);
	wire lastIsAccuse;
	assign lastIsAccuse = (txLeft_r == {{KSCHED_W{1'b0}}, 1'b1});
	wire weSched;
	assign weSched = isBiu && (schedNode_r == nodeId_r);
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			txLeft_r <= {(KSCHED_W+1){1'b0}};
			diiCnt_r <= 32'h00000000;
			txStrobe_r <= 1'b0;
			txMessage_r <= {MSG_W{1'b0}};
			peRead_r <= 1'b0;
			peStrobe_r <= 1'b0;
			peOutMessage_r <= {MSG_W{1'b0}};
		end else if (resetIn) begin
			txLeft_r <= {(KSCHED_W+1){1'b0}};
			diiCnt_r <= 32'h00000000;
			txStrobe_r <= 1'b0;
			peRead_r <= 1'b0;
			peStrobe_r <= 1'b0;
		end else begin
			txStrobe_r <= 1'b0;
			peRead_r <= 1'b0;
			peStrobe_r <= 1'b0;
			if (startPulse && cmdAllowed && cmdMode == `MODE_BROADCAST) begin
				txLeft_r <= {1'b0, cmdSchedCount} + 1'b1;
				diiCnt_r <= 32'h00000000;
			end else if (txTick) begin
				txLeft_r <= txLeft_r - 1'b1;
				diiCnt_r <= DIIM1;
				txStrobe_r <= 1'b1;
				if (lastIsAccuse || !weSched)
					txMessage_r <= {{(MSG_W-NSRC){1'b0}}, accusation_r};
				else begin
					txMessage_r <= peMessage;
					peRead_r <= 1'b1;
				end
			end else if (diiCnt_r != 32'h00000000) begin
				diiCnt_r <= diiCnt_r - 1'b1;
			end
			// Delivered broadcast data reaches the element only as interface unit
			if (isBiu && state_r == ST_RUN && activeMode_r == `MODE_BROADCAST) begin
				peStrobe_r <= rxStrobe[0] && !rxSynd[0];
				peOutMessage_r <= rxMessage[MSG_W-1:0];
			end
		end
	end
endmodule // bus_supervisor

// ===== verilog/bus_supervisor_consts.vh
/*
 Timing counts, minor-mode codes and field layout of the received message word.
 Assumes inclusion by bare name from the supervisor design files.
*/
`ifndef BUS_SUPERVISOR_CONSTS_VH
`define BUS_SUPERVISOR_CONSTS_VH
`define CLK_PERIOD_NS 5
`define SYNC_TIMEOUT_NS 20000
`define SYNC_TIMEOUT_CYC (`SYNC_TIMEOUT_NS / `CLK_PERIOD_NS)
`define RESYNC_TIMEOUT_NS 100000
`define RESYNC_TIMEOUT_CYC (`RESYNC_TIMEOUT_NS / `CLK_PERIOD_NS)
`define MODE_W 3
`define MODE_IDLE 3'h0
`define MODE_SELFTEST 3'h1
`define MODE_FRAMESYNC 3'h2
`define MODE_CAPTURE 3'h3
`define MODE_INITSYNC 3'h4
`define MODE_PRESERVE 3'h5
`define MODE_DIAG 3'h6
`define MODE_BROADCAST 3'h7
`define MSG_TYPE_LSB 0
`define MSG_TYPE_W 2
`define MSG_SYNC 2'h1
`define MSG_FRAME 2'h2
`define MSG_DATA 2'h3
`define KIND_BIU 1'b0
`endif

// ===== verilog/input_error_monitor.v
/*
 Per-source input-error monitor: checks message-type sequence against the active mode.
 Assumes strobes and message fields synchronous to sys_clk.
*/
`timescale 1ns/1ps
`include "bus_supervisor_consts.vh"
module input_error_monitor #(
	parameter MSG_W = 16
) (
	input wire sys_clk,
	input wire rstn,
	input wire clear,
	input wire [`MODE_W-1:0] mode,
	input wire strobe,
	input wire [MSG_W-1:0] message,
	input wire rxSynd,
	output reg accuse_r,
	output reg syncSeen_r
);
	wire [`MSG_TYPE_W-1:0] msgType;
	reg bad;
	assign msgType = message[`MSG_TYPE_LSB +: `MSG_TYPE_W];
	always @* begin
		bad = 1'b0;
		if (strobe) begin
			case (mode)
				`MODE_FRAMESYNC: bad = rxSynd || (msgType != `MSG_FRAME);
				`MODE_CAPTURE, `MODE_INITSYNC: bad = rxSynd || (msgType != `MSG_SYNC) || syncSeen_r;
				default: bad = 1'b0;
			endcase
		end
	end
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			accuse_r <= 1'b0;
			syncSeen_r <= 1'b0;
		end else begin
			// Accusation stands immediately, set wins over clear
			if (bad)
				accuse_r <= 1'b1;
			else if (clear)
				accuse_r <= 1'b0;
			if (clear)
				syncSeen_r <= 1'b0;
			else if (strobe && msgType == `MSG_SYNC && !bad)
				syncSeen_r <= 1'b1;
		end
	end
endmodule // input_error_monitor
